// ---- core/rst_comb_pkg.sv ----
// Function
// RL1: merge all sources into one master reset
// RL2: any active source asserts master reset
// RL3: illegal opcode, uninit register, security raise illegal
// RL4: master reset forces some registers, keeps others
// RL5: each reset kind sets its own cause bit
// RL6: power-on clears causes, sets bit zero only
// RL7: software may set or clear any cause bit
// RL8: writing cause bits never causes a reset
// RL9: software clears cause bits after reading them
// RL10: simultaneous sources each set their own bit
// RL11: hold while active, release synchronously when idle
package rst_comb_pkg;

  // one bit per reset kind, power-on in bit 0
  typedef struct packed {
    logic illegalCond;   // illegal opcode, uninit register, security
    logic trapConflict;  // trap conflict
    logic cfgMismatch;   // configuration mismatch
    logic watchdog;      // watchdog timeout
    logic resetInstr;    // reset instruction
    logic extClear;      // external clear pin
    logic brownOut;      // brown-out
    logic powerOn;       // power-on
  } src_t;

  // register selector after address decode
  typedef enum logic [2:0] {
    SEL_CAUSE,
    SEL_LIVE,
    SEL_CTRL,
    SEL_SCRATCH,
    SEL_NONE
  } reg_sel_t;

  localparam int          ADDR_W       = 8;       // axi address width
  localparam int          DATA_W       = 32;      // axi data width
  localparam int          CAUSE_W      = 8;       // cause bits
  localparam logic [7:0]  OFS_CAUSE    = 8'h00;   // reset cause register
  localparam logic [7:0]  OFS_LIVE     = 8'h04;   // live source levels
  localparam logic [7:0]  OFS_CTRL     = 8'h08;   // release stretch count
  localparam logic [7:0]  OFS_SCRATCH  = 8'h0c;   // cleared by master reset
  localparam logic [7:0]  POR_CAUSE    = 8'h01;   // power-on bit only
  localparam logic [7:0]  CTRL_RST     = 8'h00;   // no stretch
  localparam logic [7:0]  SCRATCH_RST  = 8'h00;   // forced value
  localparam logic [7:0]  ZERO8        = 8'h00;
  localparam int          LIVE_MRST    = 8;       // master reset bit in live
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage : rst_comb_pkg

// ---- core/cause_store.sv ----
`timescale 1ns/1ns
// sticky reset cause bits; cleared only by power-on or a software write
module cause_store (
  // clock and power-on reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // hardware set, software write
  input  wire logic [rst_comb_pkg::CAUSE_W-1:0] setBits,
  input  wire logic                          wrEn,
  input  wire logic [rst_comb_pkg::CAUSE_W-1:0] wrData,
  // registered contents
  output logic      [rst_comb_pkg::CAUSE_W-1:0] causeBits
);

  logic [rst_comb_pkg::CAUSE_W-1:0] cause_next;  // value after this edge

  // software write first, then hardware sets on top so a set wins
  always_comb begin
    cause_next = causeBits;
    if (wrEn) begin
      cause_next = wrData;  // RL7
    end
    cause_next = cause_next | setBits;  // RL5 RL10
  end

  // power-on leaves only its own bit; master reset does not touch this
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      causeBits <= rst_comb_pkg::POR_CAUSE;  // RL6
    end else begin
      causeBits <= cause_next;
    end
  end

endmodule : cause_store

// ---- core/reset_source_combiner.sv ----
`timescale 1ns/1ns
// gathers reset sources into one master reset and records the cause
module reset_source_combiner (
  // clock and power-on reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  // sources from outside the clock domain
  input  wire logic                              brownOutDetect,
  input  wire logic                              extClearPin_n,
  // sources from logic on ref_clk
  input  wire logic                              resetInstruction,
  input  wire logic                              watchdogTimeout,
  input  wire logic                              configurationMismatch,
  input  wire logic                              trapConflict,
  input  wire logic                              illegalOpcode,
  input  wire logic                              uninitWorkingReg,
  input  wire logic                              securityViolation,
  // axi4-lite write channels
  input  wire logic [rst_comb_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [rst_comb_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // axi4-lite read channels
  input  wire logic [rst_comb_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [rst_comb_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // device-wide reset
  output logic                                   masterSystemReset
);

  // address decode, shared by the read and write paths
  function automatic rst_comb_pkg::reg_sel_t decodeAddr(
    input logic [rst_comb_pkg::ADDR_W-1:0] addr
  );
    case (addr)
      rst_comb_pkg::OFS_CAUSE:   decodeAddr = rst_comb_pkg::SEL_CAUSE;
      rst_comb_pkg::OFS_LIVE:    decodeAddr = rst_comb_pkg::SEL_LIVE;
      rst_comb_pkg::OFS_CTRL:    decodeAddr = rst_comb_pkg::SEL_CTRL;
      rst_comb_pkg::OFS_SCRATCH: decodeAddr = rst_comb_pkg::SEL_SCRATCH;
      default:                   decodeAddr = rst_comb_pkg::SEL_NONE;
    endcase
  endfunction : decodeAddr

  logic                               brownMeta_reg;   // sync stage 1
  logic                               brownSync_reg;   // sync stage 2
  logic                               clearMeta_reg;   // sync stage 1, active low
  logic                               clearSync_reg;   // sync stage 2, active low
  rst_comb_pkg::src_t                 srcNow;          // sources seen this cycle
  logic                               anyActive;       // at least one source
  logic [7:0]                         holdCnt_reg;     // release stretch
  logic [7:0]                         ctrl_reg;        // stretch setting
  logic [7:0]                         scratch_reg;     // forced by master reset
  logic [rst_comb_pkg::CAUSE_W-1:0]   causeBits;       // from cause store
  logic [rst_comb_pkg::ADDR_W-1:0]    awAddr_reg;      // held write address
  logic [rst_comb_pkg::DATA_W-1:0]    wData_reg;       // held write data
  logic [3:0]                         wStrb_reg;       // held strobes
  logic                               awHeld_reg;      // address taken
  logic                               wHeld_reg;       // data taken
  logic                               wrFire;          // write performed now
  rst_comb_pkg::reg_sel_t             wrSel;           // write target
  logic                               wrLane0;         // low byte enabled
  rst_comb_pkg::reg_sel_t             rdSel;           // read target

  // pins pass two flops before anything looks at them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brownMeta_reg <= 1'b0;
      brownSync_reg <= 1'b0;
      clearMeta_reg <= 1'b1;
      clearSync_reg <= 1'b1;
    end else begin
      brownMeta_reg <= brownOutDetect;
      brownSync_reg <= brownMeta_reg;
      clearMeta_reg <= extClearPin_n;
      clearSync_reg <= clearMeta_reg;
    end
  end

  // source vector; power-on is rst_n itself, caught by the cause store
  always_comb begin
    srcNow              = '0;
    srcNow.powerOn      = 1'b0;
    srcNow.brownOut     = brownSync_reg;
    srcNow.extClear     = ~clearSync_reg;
    srcNow.resetInstr   = resetInstruction;
    srcNow.watchdog     = watchdogTimeout;
    srcNow.cfgMismatch  = configurationMismatch;
    srcNow.trapConflict = trapConflict;
    srcNow.illegalCond  = illegalOpcode | uninitWorkingReg | securityViolation;  // RL3
    anyActive           = |srcNow;  // RL1 RL2
  end

  // stretch counter reloads while any source is active
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_reg <= rst_comb_pkg::ZERO8;
    end else if (anyActive) begin
      holdCnt_reg <= ctrl_reg;
    end else if (holdCnt_reg != rst_comb_pkg::ZERO8) begin
      holdCnt_reg <= holdCnt_reg - 8'h01;
    end
  end

  // master reset: set by any source, released on a clock edge only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterSystemReset <= 1'b1;  // power-on holds the device
    end else begin
      masterSystemReset <= anyActive | (holdCnt_reg != rst_comb_pkg::ZERO8);  // RL2 RL11
    end
  end

  // write decode; a cause write only flips flags, it is no source
  assign wrFire  = awHeld_reg & wHeld_reg & ~bvalid;
  assign wrSel   = decodeAddr(awAddr_reg);
  assign wrLane0 = wStrb_reg[0];

  // cause flags survive master reset, cleared by power-on or a software write
  cause_store u_cause (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .setBits   (srcNow),
    .wrEn      (wrFire && wrSel == rst_comb_pkg::SEL_CAUSE && wrLane0),  // RL7 RL8
    .wrData    (wData_reg[rst_comb_pkg::CAUSE_W-1:0]),
    .causeBits (causeBits)
  );

  // stretch setting is kept across master reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rst_comb_pkg::CTRL_RST;
    end else if (wrFire && wrSel == rst_comb_pkg::SEL_CTRL && wrLane0) begin
      ctrl_reg <= wData_reg[7:0];
    end
  end

  // scratch stands for the registers that master reset forces
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= rst_comb_pkg::SCRATCH_RST;
    end else if (masterSystemReset) begin
      scratch_reg <= rst_comb_pkg::SCRATCH_RST;  // RL4
    end else if (wrFire && wrSel == rst_comb_pkg::SEL_SCRATCH && wrLane0) begin
      scratch_reg <= wData_reg[7:0];
    end
  end

  // write channels: address and data in either order, then response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= rst_comb_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHeld_reg <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wHeld_reg <= 1'b1;
        wready    <= 1'b0;
      end
      if (wrFire) begin
        // live register is read only, so a write there is refused too
        bvalid     <= 1'b1;
        bresp      <= (wrSel == rst_comb_pkg::SEL_NONE || wrSel == rst_comb_pkg::SEL_LIVE)
                      ? rst_comb_pkg::RESP_SLVERR : rst_comb_pkg::RESP_OKAY;
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channel answers one cycle after the address is taken
  assign rdSel = decodeAddr(araddr);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= rst_comb_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= rst_comb_pkg::RESP_OKAY;
      rdata   <= '0;
      case (rdSel)
        rst_comb_pkg::SEL_CAUSE:   rdata[rst_comb_pkg::CAUSE_W-1:0] <= causeBits;
        rst_comb_pkg::SEL_LIVE: begin
          rdata[7:0]                    <= srcNow;
          rdata[rst_comb_pkg::LIVE_MRST] <= masterSystemReset;
        end
        rst_comb_pkg::SEL_CTRL:    rdata[7:0] <= ctrl_reg;
        rst_comb_pkg::SEL_SCRATCH: rdata[7:0] <= scratch_reg;
        default:                   rresp <= rst_comb_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // helper: low only in the first sampled cycle after power-on
  logic porSeen_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      porSeen_reg <= 1'b0;
    end else begin
      porSeen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_any_src_asserts: assert property (anyActive |=> masterSystemReset) // RL2
    else $error("source active but master reset low");
  a_release_when_idle: assert property ( // RL11
    (!anyActive && holdCnt_reg == rst_comb_pkg::ZERO8) |=> !masterSystemReset)
    else $error("master reset held with no source");
  a_hold_while_active: assert property (anyActive [*2] |-> masterSystemReset) // RL11
    else $error("master reset dropped while source active");
  a_each_cause_set: assert property ( // RL10
    (srcNow != '0) |=> ((causeBits & $past(srcNow)) == $past(srcNow)))
    else $error("active source left its cause bit clear");
  a_sw_write_lands: assert property ( // RL7
    (wrFire && wrSel == rst_comb_pkg::SEL_CAUSE && wrLane0 && srcNow == '0)
    |=> causeBits == $past(wData_reg[7:0]))
    else $error("cause write not stored");
  a_write_no_reset: assert property ( // RL8
    (wrFire && !anyActive && holdCnt_reg == rst_comb_pkg::ZERO8) |=> !masterSystemReset)
    else $error("register write caused a reset");
  a_por_cause_value: assert property (!porSeen_reg |-> causeBits == rst_comb_pkg::POR_CAUSE) // RL6
    else $error("cause after power-on is not bit zero only");
  a_scratch_forced: assert property ( // RL4
    masterSystemReset |=> scratch_reg == rst_comb_pkg::SCRATCH_RST)
    else $error("scratch not forced by master reset");

  c_two_sources: cover property ($countones(srcNow) >= 2);
  c_cause_written: cover property (wrFire && wrSel == rst_comb_pkg::SEL_CAUSE);
  c_stretch_release: cover property (!anyActive && holdCnt_reg == 8'h01 ##1 masterSystemReset);
  c_bad_read: cover property (rvalid && rresp == rst_comb_pkg::RESP_SLVERR);

endmodule : reset_source_combiner

// ---- bench/reset_source_gen.sv ----
`timescale 1ns/1ns
// far-side reset generators: fires a chosen set of sources for a span
module reset_source_gen (
  // clock and power-on reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // request from the bench
  input  wire logic       fire,
  input  wire logic [8:0] pattern,
  input  wire logic [3:0] holdLen,
  // bit 1 is the clear pin, active low; bits 6..8 are the illegal-condition causes
  output logic      [8:0] srcOut
);
  logic [8:0] activeReg;  // sources now active
  logic [3:0] countReg;   // cycles left to hold

  // hold holdLen+1 cycles, then release all at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeReg <= 9'h000;
      countReg  <= 4'h0;
    end else if (fire) begin
      activeReg <= pattern;
      countReg  <= holdLen;
    end else if (countReg != 4'h0) begin
      countReg <= countReg - 4'h1;
    end else begin
      activeReg <= 9'h000;
    end
  end

  // the clear pin idles high, every other source idles low
  assign srcOut = activeReg ^ 9'h002;
endmodule : reset_source_gen

// ---- bench/reset_source_combiner_tb.sv ----
`timescale 1ns/1ns
module reset_source_combiner_tb;
  logic        ref_clk, rst_n, fire, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, masterSystemReset;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, holdLen;
  logic [1:0]  bresp, rresp;
  logic [8:0]  pattern, srcOut;
  int          errors, compares;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  reset_source_gen src (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .pattern(pattern),
    .holdLen(holdLen), .srcOut(srcOut));
  reset_source_combiner uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .brownOutDetect(srcOut[0]), .extClearPin_n(srcOut[1]), .resetInstruction(srcOut[2]),
    .watchdogTimeout(srcOut[3]), .configurationMismatch(srcOut[4]), .trapConflict(srcOut[5]),
    .illegalOpcode(srcOut[6]), .uninitWorkingReg(srcOut[7]), .securityViolation(srcOut[8]),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .masterSystemReset(masterSystemReset));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // both channels offered together, each dropped when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 100);
    do begin
      @(posedge ref_clk);
      n++;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    // one idle edge keeps the next request off this step
    @(posedge ref_clk);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axiRead

  task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(name, exp, d);
    check("rresp", {30'h0, rst_comb_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rdCheck

  task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    check("bresp", {30'h0, rst_comb_pkg::RESP_OKAY}, {30'h0, r});
  endtask : wrOk

  // bounded wait until the master reset shows lvl; n counts edges
  task automatic waitMrst(input logic lvl, input int lim, output int n);
    n = 0;
    while (masterSystemReset !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : waitMrst

  task automatic fireSrc(input logic [8:0] p, input logic [3:0] len);
    pattern <= p;
    holdLen <= len;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : fireSrc

  task automatic testSoftware;
    check("mrstIdle", 32'h0, {31'h0, masterSystemReset});
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'h01, "causePor");
    wrOk(rst_comb_pkg::OFS_CAUSE, 32'hff);
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'hff, "causeSet");
    repeat (4) @(posedge ref_clk);
    check("mrstQuiet", 32'h0, {31'h0, masterSystemReset});
    rdCheck(rst_comb_pkg::OFS_LIVE, 32'h0, "live");
    wrOk(rst_comb_pkg::OFS_CAUSE, 32'h0);
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'h0, "causeClr");
  endtask : testSoftware

  task automatic testEachSource;
    int         n;
    logic [7:0] exp;
    for (int i = 0; i < 9; i++) begin
      exp = (i < 6) ? (8'h02 << i) : 8'h80;
      fireSrc(9'h001 << i, 4'h1);
      waitMrst(1'b1, 10, n);
      check("mrstUp", 32'h1, {31'h0, masterSystemReset});
      waitMrst(1'b0, 20, n);
      rdCheck(rst_comb_pkg::OFS_CAUSE, {24'h0, exp}, "causeKind");
      wrOk(rst_comb_pkg::OFS_CAUSE, 32'h0);
    end
  endtask : testEachSource

  task automatic testTogether;
    int n;
    // watchdog, trap conflict and illegal opcode in the same cycle
    fireSrc(9'h068, 4'h0);
    waitMrst(1'b1, 10, n);
    waitMrst(1'b0, 20, n);
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'hd0, "causeMulti");
    wrOk(rst_comb_pkg::OFS_CAUSE, 32'h0);
  endtask : testTogether

  task automatic testStretch;
    int n;
    wrOk(rst_comb_pkg::OFS_CTRL, 32'h03);
    rdCheck(rst_comb_pkg::OFS_CTRL, 32'h03, "ctrlSet");
    wrOk(rst_comb_pkg::OFS_SCRATCH, 32'h5a);
    rdCheck(rst_comb_pkg::OFS_SCRATCH, 32'h5a, "scratchSet");
    fireSrc(9'h008, 4'h5);
    waitMrst(1'b1, 10, n);
    waitMrst(1'b0, 40, n);
    // six active cycles plus a stretch of three
    check("mrstSpan", 32'd9, n);
    rdCheck(rst_comb_pkg::OFS_SCRATCH, 32'h0, "scratchForced");
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'h10, "causeKept");
    wrOk(rst_comb_pkg::OFS_CTRL, 32'h0);
  endtask : testStretch

  task automatic testBusErrors;
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(8'h10, d, r);
    check("unmappedResp", {30'h0, rst_comb_pkg::RESP_SLVERR}, {30'h0, r});
    check("unmappedData", 32'h0, d);
    axiWrite(rst_comb_pkg::OFS_LIVE, 32'hff, r);
    check("liveWrResp", {30'h0, rst_comb_pkg::RESP_SLVERR}, {30'h0, r});
    // low byte lane off: answered okay, cause bits left as they were
    wstrb <= 4'h0;
    wrOk(rst_comb_pkg::OFS_CAUSE, 32'hff);
    wstrb <= 4'hf;
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'h10, "causeNoLane");
  endtask : testBusErrors

  task automatic testPowerOn;
    wrOk(rst_comb_pkg::OFS_CAUSE, 32'hfe);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdCheck(rst_comb_pkg::OFS_CAUSE, 32'h01, "causeRepor");
  endtask : testPowerOn

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    finish_test();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    fire = 1'b0;
    pattern = 9'h000;
    holdLen = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // master reset falls on the first edge after release, so look one edge later
    repeat (2) @(posedge ref_clk);
    testSoftware();
    testEachSource();
    testTogether();
    testStretch();
    testBusErrors();
    testPowerOn();
    finish_test();
  end
endmodule : reset_source_combiner_tb
